/* File: cswk_bus_model.sv */
// Bus side model: hands received headers to the block, drives tx pin.
// Assumes bench requests change just after a rising clock edge.
`timescale 1ns/1ps
module cswk_bus_model (
  // Clock
  input wire mclk_in,
  // Bench requests
  input wire send_in,
  input wire [28:0] ident_in,
  input wire ide_in,
  input wire rtr_in,
  input wire trim_run_in,
  // Toward the block
  output reg frame_valid_out,
  output reg [28:0] frame_ident_out,
  output reg frame_ide_out,
  output reg frame_rtr_out,
  output reg bus_tx_out
);
  reg [1:0] div_reg = 2'h0;
  initial begin
    {frame_valid_out, frame_ident_out, frame_ide_out, frame_rtr_out} = 0;
    bus_tx_out = 1'b1;
  end
  always @(posedge mclk_in) begin
    frame_valid_out <= send_in;
    // Header inverts each cycle outside valid, so stale values return every other cycle
    frame_ident_out <= send_in ? ident_in : ~frame_ident_out;
    frame_ide_out <= send_in ? ide_in : ~frame_ide_out;
    frame_rtr_out <= send_in ? rtr_in : ~frame_rtr_out;
    div_reg <= div_reg + 2'h1;
    bus_tx_out <= trim_run_in ? div_reg[1] : 1'b1;
  end
endmodule // cswk_bus_model

/* File: cswk_consts.vh */
// Constants for the selective wake configuration block.
// Included by cswk_filter_config.v; holds definitions only.
`ifndef CSWK_CONSTS_VH
`define CSWK_CONSTS_VH

// Register addresses (7-bit serial port address space)
`define CSWK_ADDR_CONTROL 7'h20
`define CSWK_ADDR_QUANTA 7'h21
`define CSWK_ADDR_SAMPLE 7'h22
`define CSWK_ADDR_ID3 7'h23
`define CSWK_ADDR_ID2 7'h24
`define CSWK_ADDR_ID1 7'h25
`define CSWK_ADDR_ID0 7'h26
`define CSWK_ADDR_MASK3 7'h27

// Reset values
`define CSWK_RST_CONTROL 8'h00
`define CSWK_RST_QUANTA 8'hA0
`define CSWK_RST_SAMPLE 6'h33
`define CSWK_RST_ZERO 8'h00

// Control register field positions
`define CSWK_CTL_VALID 0
`define CSWK_CTL_TO_IRQ 4
`define CSWK_CTL_UNLOCK_LO 5
`define CSWK_CTL_UNLOCK_HI 6
`define CSWK_CTL_OSC_CALIBRATE_EN 7
`define CSWK_UNLOCK_CODE 2'h3

// Identifier low register field positions
`define CSWK_ID0_IDE 0
`define CSWK_ID0_RTR 1
`define CSWK_ID0_LOW_LSB 2
`define CSWK_ID0_LOW_MSB 6

// Channel mode field: top bit enables frame wake
`define CSWK_MODE_SWK_BIT 2

`endif

/* File: cswk_filter_config.v */
// Selective wake configuration registers and wake frame match.
// Assumes a decoded serial register port (address, data, write and
// read strobes) and a frame decoder presenting received headers,
// all synchronous to mclk_in. Only the bus transmit pin is external.
`timescale 1ns/1ps
`include "cswk_consts.vh"

// Contract
// - Wake matching only while setup_valid set
// - Wake event and reset clear setup_valid
// - Configuration change clears setup_valid
// - Stop-mode configuration write invalidates setup
// - Calibration unlocked only by code 11
// - Option register writes need unlock 11
// - Calibrate oscillator from bus transmit input
// - Timeout mask bit gates interrupt output
// - Timeout flag updates only with frame wake
// - Quanta per bit register, reset A0
// - Six-bit sample fraction, upper bits zero
// - Identifier spread over four registers
// - IDE bit selects standard or extended
// - Mask one compares, zero ignores bit
// - Reserved bits ignore writes, read zero
// - Restart clears valid bit, keeps rest
// - Mode field top bit enables selective wake
module cswk_filter_config #(
  parameter ADDR_W = 7,
  parameter ID_W = 29
) (
  // Clock and reset
  input wire mclk_in,
  input wire reset_in,
  input wire soft_reset_in,
  input wire restart_in,
  // Register port
  input wire [ADDR_W-1:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_write_in,
  input wire reg_read_in,
  input wire reg_opt_write_in,
  input wire reg_can_cfg_write_in,
  output reg [7:0] reg_rdata_out,
  output reg reg_opt_accept_out,
  // Device mode and channel
  input wire stop_mode_in,
  input wire [2:0] chan_mode_in,
  // Received frame header, other wake and bus timeout
  input wire frame_valid_in,
  input wire [ID_W-1:0] frame_ident_in,
  input wire frame_ide_in,
  input wire frame_rtr_in,
  input wire other_wake_in,
  input wire bus_timeout_in,
  // Bus transmit pin
  input wire bus_tx_input,
  // Results
  output reg wake_frame_out,
  output reg setup_valid_out,
  output reg bus_timeout_flag_out,
  output reg irq_out_n,
  output reg osc_calibrate_en_out,
  output reg osc_trim_edge_out,
  output reg [7:0] quanta_per_bit_out,
  output reg [5:0] sample_fraction_out
);

  reg [7:0] control_reg;
  reg [7:0] quanta_reg;
  reg [5:0] sample_reg;
  reg [7:0] ident_hi_byte_reg;
  reg [7:0] ident_mid_byte_reg;
  reg [7:0] ident_lo_byte_reg;
  reg [4:0] ident_low_five_reg;
  reg ide_reg;
  reg rtr_reg;
  reg [7:0] ident_compare_hi_reg;
  reg [2:0] tx_sync_reg;
  reg tx_level_reg;
  reg timeout_seen_reg;

  wire unlocked;
  wire chan_frame_wake_en;
  wire cfg_write;
  wire [ID_W-1:0] stored_ident;
  wire [ID_W-1:0] compare_mask;
  wire match;
  // One write strobe per mapped register
  wire wr_control;
  wire wr_quanta;
  wire wr_sample;
  wire wr_ident3;
  wire wr_ident2;
  wire wr_ident1;
  wire wr_ident0;
  wire wr_mask3;

  assign unlocked = (control_reg[`CSWK_CTL_UNLOCK_HI:`CSWK_CTL_UNLOCK_LO] == `CSWK_UNLOCK_CODE);
  // top mode bit enables frame wake
  assign chan_frame_wake_en = chan_mode_in[`CSWK_MODE_SWK_BIT];

  // Writes to any setup data register besides control
  function is_cfg_addr;
    input [ADDR_W-1:0] a;
    begin
      is_cfg_addr = (a == `CSWK_ADDR_QUANTA) || (a == `CSWK_ADDR_SAMPLE) ||
        (a == `CSWK_ADDR_ID3) || (a == `CSWK_ADDR_ID2) || (a == `CSWK_ADDR_ID1) ||
        (a == `CSWK_ADDR_ID0) || (a == `CSWK_ADDR_MASK3);
    end
  endfunction

  assign cfg_write = reg_write_in && is_cfg_addr(reg_addr_in);

  // Address decode shared by the register processes
  assign wr_control = reg_write_in && (reg_addr_in == `CSWK_ADDR_CONTROL);
  assign wr_quanta = reg_write_in && (reg_addr_in == `CSWK_ADDR_QUANTA);
  assign wr_sample = reg_write_in && (reg_addr_in == `CSWK_ADDR_SAMPLE);
  assign wr_ident3 = reg_write_in && (reg_addr_in == `CSWK_ADDR_ID3);
  assign wr_ident2 = reg_write_in && (reg_addr_in == `CSWK_ADDR_ID2);
  assign wr_ident1 = reg_write_in && (reg_addr_in == `CSWK_ADDR_ID1);
  assign wr_ident0 = reg_write_in && (reg_addr_in == `CSWK_ADDR_ID0);
  assign wr_mask3 = reg_write_in && (reg_addr_in == `CSWK_ADDR_MASK3);

  assign stored_ident = {ident_hi_byte_reg, ident_mid_byte_reg, ident_lo_byte_reg, ident_low_five_reg};
  // Mask bits below 21 are not held here and compare fully
  assign compare_mask = {ident_compare_hi_reg, {(ID_W-8){1'b1}}};

  // identifier, IDE and RTR must all agree
  assign match = (((frame_ident_in ^ stored_ident) & compare_mask) == {ID_W{1'b0}}) &&
    (frame_ide_in == ide_reg) && (frame_rtr_in == rtr_reg);

  // soft reset loads the same values as reset, restart keeps
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      control_reg <= `CSWK_RST_CONTROL;
    end else if (soft_reset_in) begin
      control_reg <= `CSWK_RST_CONTROL;
    end else if (wr_control) begin
      control_reg[7:4] <= reg_wdata_in[7:4];
      control_reg[3:1] <= 3'h0;
    end
  end

  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      quanta_reg <= `CSWK_RST_QUANTA;
    end else if (soft_reset_in) begin
      quanta_reg <= `CSWK_RST_QUANTA;
    end else if (wr_quanta) begin
      quanta_reg <= reg_wdata_in;
    end
  end

  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      sample_reg <= `CSWK_RST_SAMPLE;
    end else if (soft_reset_in) begin
      sample_reg <= `CSWK_RST_SAMPLE;
    end else if (wr_sample) begin
      sample_reg <= reg_wdata_in[5:0];
    end
  end

  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ident_hi_byte_reg <= `CSWK_RST_ZERO;
    end else if (soft_reset_in) begin
      ident_hi_byte_reg <= `CSWK_RST_ZERO;
    end else if (wr_ident3) begin
      ident_hi_byte_reg <= reg_wdata_in;
    end
  end

  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ident_mid_byte_reg <= `CSWK_RST_ZERO;
    end else if (soft_reset_in) begin
      ident_mid_byte_reg <= `CSWK_RST_ZERO;
    end else if (wr_ident2) begin
      ident_mid_byte_reg <= reg_wdata_in;
    end
  end

  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ident_lo_byte_reg <= `CSWK_RST_ZERO;
    end else if (soft_reset_in) begin
      ident_lo_byte_reg <= `CSWK_RST_ZERO;
    end else if (wr_ident1) begin
      ident_lo_byte_reg <= reg_wdata_in;
    end
  end

  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ident_low_five_reg <= 5'h00;
      rtr_reg <= 1'b0;
      ide_reg <= 1'b0;
    end else if (soft_reset_in) begin
      ident_low_five_reg <= 5'h00;
      rtr_reg <= 1'b0;
      ide_reg <= 1'b0;
    end else if (wr_ident0) begin
      ident_low_five_reg <= reg_wdata_in[`CSWK_ID0_LOW_MSB:`CSWK_ID0_LOW_LSB];
      rtr_reg <= reg_wdata_in[`CSWK_ID0_RTR];
      ide_reg <= reg_wdata_in[`CSWK_ID0_IDE];
    end
  end

  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ident_compare_hi_reg <= `CSWK_RST_ZERO;
    end else if (soft_reset_in) begin
      ident_compare_hi_reg <= `CSWK_RST_ZERO;
    end else if (wr_mask3) begin
      ident_compare_hi_reg <= reg_wdata_in;
    end
  end

  // Valid flag: host sets it, hardware clears it
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      setup_valid_out <= 1'b0;
    end else if (soft_reset_in) begin
      setup_valid_out <= 1'b0;
    end else if (restart_in) begin
      // restart clears only the valid bit
      setup_valid_out <= 1'b0;
    end else if (wake_frame_out || other_wake_in) begin
      setup_valid_out <= 1'b0;
    end else if (cfg_write) begin
      // same edge as the data write
      setup_valid_out <= 1'b0;
    end else if (stop_mode_in && reg_can_cfg_write_in) begin
      setup_valid_out <= 1'b0;
    end else if (reg_write_in && (reg_addr_in == `CSWK_ADDR_CONTROL)) begin
      setup_valid_out <= reg_wdata_in[`CSWK_CTL_VALID];
    end
  end

  // Wake decision, timeout flag and interrupt
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      wake_frame_out <= 1'b0;
      timeout_seen_reg <= 1'b0;
      bus_timeout_flag_out <= 1'b0;
      irq_out_n <= 1'b1;
    end else if (soft_reset_in) begin
      wake_frame_out <= 1'b0;
      timeout_seen_reg <= 1'b0;
      bus_timeout_flag_out <= 1'b0;
      irq_out_n <= 1'b1;
    end else begin
      wake_frame_out <= frame_valid_in && setup_valid_out && chan_frame_wake_en && match && !wake_frame_out;
      // flag follows timeout only with frame wake
      if (chan_frame_wake_en) begin
        bus_timeout_flag_out <= bus_timeout_in;
      end
      timeout_seen_reg <= bus_timeout_flag_out;
      // unmasked rising timeout pulls interrupt low
      irq_out_n <= !(control_reg[`CSWK_CTL_TO_IRQ] && bus_timeout_flag_out && !timeout_seen_reg);
    end
  end

  // Transmit pin synchroniser and calibration edges
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_sync_reg <= 3'h7;
      tx_level_reg <= 1'b1;
      osc_calibrate_en_out <= 1'b0;
      osc_trim_edge_out <= 1'b0;
    end else if (soft_reset_in) begin
      tx_sync_reg <= 3'h7;
      tx_level_reg <= 1'b1;
      osc_calibrate_en_out <= 1'b0;
      osc_trim_edge_out <= 1'b0;
    end else begin
      tx_sync_reg <= {tx_sync_reg[1:0], bus_tx_input};
      if (tx_sync_reg[2] == tx_sync_reg[1]) begin
        tx_level_reg <= tx_sync_reg[1];
      end
      // trim only with calibration bit and unlock
      osc_calibrate_en_out <= control_reg[`CSWK_CTL_OSC_CALIBRATE_EN] && unlocked;
      osc_trim_edge_out <= osc_calibrate_en_out && tx_level_reg &&
        (tx_sync_reg[2] == tx_sync_reg[1]) && !tx_sync_reg[1];
    end
  end

  // Read data, option acceptance and timing outputs
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= 8'h00;
      reg_opt_accept_out <= 1'b0;
      quanta_per_bit_out <= `CSWK_RST_QUANTA;
      sample_fraction_out <= `CSWK_RST_SAMPLE;
    end else if (soft_reset_in) begin
      // Copies show reset values one edge after soft reset
      reg_rdata_out <= 8'h00;
      reg_opt_accept_out <= 1'b0;
      quanta_per_bit_out <= `CSWK_RST_QUANTA;
      sample_fraction_out <= `CSWK_RST_SAMPLE;
    end else begin
      // option write taken only when unlocked
      reg_opt_accept_out <= reg_opt_write_in && unlocked;
      quanta_per_bit_out <= quanta_reg;
      sample_fraction_out <= sample_reg;
      if (reg_read_in) begin
        if (reg_addr_in == `CSWK_ADDR_CONTROL) begin
          reg_rdata_out <= {control_reg[7:1], setup_valid_out};
        end else if (reg_addr_in == `CSWK_ADDR_QUANTA) begin
          reg_rdata_out <= quanta_reg;
        end else if (reg_addr_in == `CSWK_ADDR_SAMPLE) begin
          reg_rdata_out <= {2'h0, sample_reg};
        end else if (reg_addr_in == `CSWK_ADDR_ID3) begin
          reg_rdata_out <= ident_hi_byte_reg;
        end else if (reg_addr_in == `CSWK_ADDR_ID2) begin
          reg_rdata_out <= ident_mid_byte_reg;
        end else if (reg_addr_in == `CSWK_ADDR_ID1) begin
          reg_rdata_out <= ident_lo_byte_reg;
        end else if (reg_addr_in == `CSWK_ADDR_ID0) begin
          reg_rdata_out <= {1'b0, ident_low_five_reg, rtr_reg, ide_reg};
        end else if (reg_addr_in == `CSWK_ADDR_MASK3) begin
          reg_rdata_out <= ident_compare_hi_reg;
        end else begin
          reg_rdata_out <= 8'h00;
        end
      end
    end
  end

endmodule // cswk_filter_config

/* File: cswk_filter_config_chk.sv */
// Port checker for the selective wake configuration block.
// Assumes one clock and an async active high reset.
`timescale 1ns/1ps
module cswk_filter_config_chk #(
  parameter ADDR_W = 7
) (
  // Clock and reset
  input wire mclk_in,
  input wire reset_in,
  input wire soft_reset_in,
  input wire restart_in,
  // Register port
  input wire [ADDR_W-1:0] reg_addr_in,
  input wire reg_write_in,
  input wire reg_read_in,
  input wire reg_opt_write_in,
  input wire reg_can_cfg_write_in,
  input wire [7:0] reg_rdata_out,
  input wire reg_opt_accept_out,
  // Mode and results
  input wire stop_mode_in,
  input wire wake_frame_out,
  input wire setup_valid_out,
  input wire irq_out_n,
  input wire [7:0] quanta_per_bit_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  wire cfg_wr = reg_write_in && reg_addr_in > 7'h20 && reg_addr_in < 7'h28;
  a_wake_needs_valid: assert property (wake_frame_out |-> $past(setup_valid_out))
    else $error("wake while not armed");
  a_wake_clears_valid: assert property (wake_frame_out |=> !setup_valid_out)
    else $error("valid kept after wake");
  a_cfg_clears_valid: assert property (cfg_wr |=> !setup_valid_out)
    else $error("valid kept after config write");
  a_stop_write_invalid: assert property (stop_mode_in && reg_can_cfg_write_in |=> !setup_valid_out)
    else $error("valid kept after stop write");
  a_restart_clears: assert property (restart_in |=> !setup_valid_out)
    else $error("valid kept after restart");
  a_opt_needs_try: assert property (reg_opt_accept_out |-> $past(reg_opt_write_in))
    else $error("option accept without write");
  a_irq_one_cycle: assert property (!irq_out_n |=> irq_out_n)
    else $error("interrupt pulse too long");
  a_sample_top_zero: assert property (reg_read_in && reg_addr_in == 7'h22 |=> reg_rdata_out[7:6] == 2'h0)
    else $error("sample upper bits set");
  a_soft_reset_vals: assert property (soft_reset_in |=> quanta_per_bit_out == 8'hA0 && !setup_valid_out)
    else $error("soft reset values wrong");
endmodule // cswk_filter_config_chk

bind cswk_filter_config cswk_filter_config_chk #(.ADDR_W(ADDR_W)) chk (.mclk_in, .reset_in, .soft_reset_in,
  .restart_in, .reg_addr_in, .reg_write_in, .reg_read_in, .reg_opt_write_in, .reg_can_cfg_write_in,
  .reg_rdata_out, .reg_opt_accept_out, .stop_mode_in, .wake_frame_out, .setup_valid_out, .irq_out_n,
  .quanta_per_bit_out);

/* File: tb_cswk_filter_config.sv */
// Self-checking bench for the selective wake configuration block.
// Assumes the bus model and the bound checker are compiled first.
`timescale 1ns/1ps
module tb_cswk_filter_config;
  reg mclk_in, reset_in, soft_reset_in, restart_in, reg_write_in, reg_read_in, reg_opt_write_in;
  reg reg_can_cfg_write_in, stop_mode_in, other_wake_in, bus_timeout_in, send, rtr, trim;
  reg [6:0] reg_addr_in;
  reg [7:0] reg_wdata_in, seen;
  reg [2:0] chan_mode_in;
  reg [28:0] id;
  wire frame_valid_in, frame_ide_in, frame_rtr_in, bus_tx_input, reg_opt_accept_out, wake_frame_out;
  wire setup_valid_out, bus_timeout_flag_out, irq_out_n, osc_calibrate_en_out, osc_trim_edge_out;
  wire [28:0] frame_ident_in;
  wire [7:0] reg_rdata_out, quanta_per_bit_out;
  wire [5:0] sample_fraction_out;
  integer fail_count = 0, num_checks = 0, trims = 0, irqs = 0, i;
  logic [7:0] rst_v [9] = '{8'h00, 8'hA0, 8'h33, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] ff_v [9] = '{8'hF0, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'h00};
  localparam [28:0] WID = {8'hA5, 8'h3C, 8'h0F, 5'h13};
  localparam [28:0] B28 = 29'h1000_0000;
  cswk_filter_config DUT (.mclk_in, .reset_in, .soft_reset_in, .restart_in, .reg_addr_in, .reg_wdata_in,
    .reg_write_in, .reg_read_in, .reg_opt_write_in, .reg_can_cfg_write_in, .reg_rdata_out,
    .reg_opt_accept_out, .stop_mode_in, .chan_mode_in, .frame_valid_in, .frame_ident_in, .frame_ide_in,
    .frame_rtr_in, .other_wake_in, .bus_timeout_in, .bus_tx_input, .wake_frame_out, .setup_valid_out,
    .bus_timeout_flag_out, .irq_out_n, .osc_calibrate_en_out, .osc_trim_edge_out, .quanta_per_bit_out,
    .sample_fraction_out);
  cswk_bus_model bus (.mclk_in, .send_in(send), .ident_in(id), .ide_in(seen[0]), .rtr_in(rtr),
    .trim_run_in(trim), .frame_valid_out(frame_valid_in), .frame_ident_out(frame_ident_in),
    .frame_ide_out(frame_ide_in), .frame_rtr_out(frame_rtr_in), .bus_tx_out(bus_tx_input));
  initial begin
    mclk_in = 0;
    forever #10 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    trims <= trims + osc_trim_edge_out;
    irqs <= irqs + !irq_out_n;
  end
  task chk(input string nm, input [7:0] s, input [7:0] e);
    num_checks = num_checks + 1;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, s);
      fail_count = fail_count + 1;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge mclk_in) #1;
  endtask
  // Write when w is set, else read and compare against d
  task rw(input w, input [6:0] a, input [7:0] d);
    cyc(1);
    reg_addr_in = a;
    reg_wdata_in = d;
    {reg_write_in, reg_read_in} = {w, !w};
    cyc(1);
    {reg_write_in, reg_read_in} = 2'b00;
    if (!w) chk("rdata", reg_rdata_out, d);
  endtask
  // Match result lands within three cycles of the header
  task frame(input [28:0] f, input ide_v, input [7:0] e);
    id = f;
    seen = 8'(ide_v);
    send = 1;
    cyc(1);
    send = 0;
    seen = 0;
    repeat (3) begin
      cyc(1);
      seen = seen | 8'(wake_frame_out);
    end
    chk("wake", seen, e);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #400000;
    fail_count = fail_count + 1;
    test_done;
  end
  initial begin
    {soft_reset_in, restart_in, reg_write_in, reg_read_in, reg_opt_write_in, reg_can_cfg_write_in} = 0;
    {stop_mode_in, other_wake_in, bus_timeout_in, send, rtr, trim, reg_addr_in, reg_wdata_in} = 0;
    {seen, id, reset_in, chan_mode_in} = {37'h0, 1'b1, 3'h5};
    cyc(6);
    reset_in = 0;
    for (i = 0; i < 9; i = i + 1) rw(0, 7'h20 + i[6:0], rst_v[i]);
    for (i = 0; i < 9; i = i + 1) rw(1, 7'h20 + i[6:0], 8'hFF);
    for (i = 0; i < 9; i = i + 1) rw(0, 7'h20 + i[6:0], ff_v[i]);
    soft_reset_in = 1;
    cyc(1);
    soft_reset_in = 0;
    chk("sample", 8'(sample_fraction_out), 8'h33);
    chk("quanta", quanta_per_bit_out, 8'hA0);
    $display("register test done");
    for (i = 0; i < 4; i = i + 1) begin
      rw(1, 7'h20, {1'b1, i[1:0], 5'h10});
      reg_opt_write_in = 1;
      cyc(1);
      reg_opt_write_in = 0;
      chk("accept", 8'(reg_opt_accept_out), 8'(i == 3));
      chk("calib", 8'(osc_calibrate_en_out), 8'(i == 3));
    end
    trim = 1;
    cyc(16);
    trim = 0;
    chk("trims", 8'(trims != 0), 8'h01);
    $display("unlock test done");
    rw(1, 7'h20, 8'h91);
    restart_in = 1;
    cyc(1);
    restart_in = 0;
    rw(0, 7'h20, 8'h90);
    rw(1, 7'h20, 8'h01);
    stop_mode_in = 1;
    reg_can_cfg_write_in = 1;
    cyc(1);
    {stop_mode_in, reg_can_cfg_write_in} = 2'b00;
    chk("valid", 8'(setup_valid_out), 8'h00);
    rw(1, 7'h20, 8'h01);
    other_wake_in = 1;
    cyc(1);
    other_wake_in = 0;
    cyc(1);
    chk("valid", 8'(setup_valid_out), 8'h00);
    $display("valid test done");
    // host keeps stored RTR at zero
    for (i = 3; i < 8; i = i + 1) rw(1, 7'h20 + i[6:0], rst_v[i] | {8'hA5, 8'h3C, 8'h0F, 8'h4D, 8'hFF} >> (8 * (7 - i)));
    rw(1, 7'h20, 8'h01);
    chk("valid", 8'(setup_valid_out), 8'h01);
    frame(WID, 1, 8'h01);
    chk("valid", 8'(setup_valid_out), 8'h00);
    frame(WID, 1, 8'h00);
    rw(1, 7'h20, 8'h01);
    frame(WID ^ B28, 1, 8'h00);
    frame(WID, 0, 8'h00);
    rtr = 1;
    frame(WID, 1, 8'h00);
    rtr = 0;
    chan_mode_in = 3'h1;
    frame(WID, 1, 8'h00);
    chan_mode_in = 3'h5;
    rw(1, 7'h27, 8'h7F);
    chk("valid", 8'(setup_valid_out), 8'h00);
    rw(1, 7'h20, 8'h01);
    frame(WID ^ B28, 1, 8'h01);
    // standard identifier placed in bits 28:18
    rw(1, 7'h23, 8'hB4);
    rw(1, 7'h24, 8'h60);
    rw(1, 7'h25, 8'h00);
    rw(1, 7'h26, 8'h00);
    rw(1, 7'h20, 8'h01);
    frame({11'h5A3, 18'h0}, 0, 8'h01);
    $display("match test done");
    chan_mode_in = 3'h1;
    bus_timeout_in = 1;
    cyc(6);
    chk("flag", 8'(bus_timeout_flag_out), 8'h00);
    chan_mode_in = 3'h5;
    cyc(6);
    chk("flag", 8'(bus_timeout_flag_out), 8'h01);
    chk("irqs", 8'(irqs), 8'h00);
    bus_timeout_in = 0;
    rw(1, 7'h20, 8'h10);
    bus_timeout_in = 1;
    cyc(6);
    chk("irqs", 8'(irqs), 8'h01);
    $display("timeout test done");
    test_done;
  end
endmodule // tb_cswk_filter_config
